// File: adc_fmt_pkg.sv
// package: register map, fields, reset values and carriers for the output formatter
package adc_fmt_pkg;
  localparam logic [7:0] ADDR_TEST_PATTERN = 8'h0d;
  localparam logic [7:0] ADDR_OFFSET_ADJUST = 8'h10;
  localparam logic [7:0] ADDR_OUTPUT_CONFIG = 8'h14;
  localparam logic [7:0] ADDR_CLOCK_EDGE = 8'h16;
  localparam logic [7:0] ADDR_REFERENCE = 8'h18;
  localparam logic [7:0] ADDR_COMMIT = 8'hff;
  localparam logic [7:0] RST_TEST_PATTERN = 8'h00;
  localparam logic [7:0] RST_OFFSET_ADJUST = 8'h00;
  localparam logic [7:0] RST_OUTPUT_CONFIG = 8'h00;
  localparam logic [7:0] RST_CLOCK_EDGE = 8'h00;
  localparam logic [7:0] RST_REFERENCE = 8'hc0;
  localparam int PAT_LSB = 0;
  localparam int SHORT_RST_BIT = 4;
  localparam int LONG_RST_BIT = 5;
  localparam int FMT_LSB = 0;
  localparam int INVERT_BIT = 2;
  localparam int DISABLE_BIT = 4;
  localparam int CLKPOL_BIT = 7;
  localparam int COMMIT_BIT = 0;
  localparam logic [22:0] LONG_PRBS_SEED = 23'h7fffff;
  localparam logic [8:0] SHORT_PRBS_SEED = 9'h1ff;

  typedef enum logic [2:0] {
    PAT_OFF = 3'h0,
    PAT_MID = 3'h1,
    PAT_POS_FS = 3'h2,
    PAT_NEG_FS = 3'h3,
    PAT_CHECKER = 3'h4,
    PAT_LONG_PRBS = 3'h5
  } pattern_t;

  typedef enum logic [1:0] {
    FMT_OFFSET_BIN = 2'h0,
    FMT_TWOS = 2'h1
  } format_t;

  typedef struct packed {
    logic [7:0] testPattern;
    logic [7:0] offsetAdjust;
    logic [7:0] outputConfig;
    logic [7:0] clockEdge;
    logic [7:0] reference;
  } regset_t;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } regreq_t;
endpackage

// File: prbs_gen.sv
// prbs generator: fibonacci lfsr with synchronous hold-in-reset
`timescale 1ns/1ns
module prbs_gen #(
  parameter int WIDTH = 23,
  parameter int TAP = 18,
  parameter logic [WIDTH-1:0] SEED = '1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic holdReset,
  input wire logic advance,
  // sequence
  output logic [WIDTH-1:0] state
);
  typedef struct packed {
    logic [WIDTH-1:0] lfsr;
  } prbs_state_t;

  prbs_state_t s_q;
  prbs_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (holdReset)
      s_d.lfsr = SEED;
    else if (advance)
      s_d.lfsr = {s_q.lfsr[WIDTH-2:0], s_q.lfsr[WIDTH-1] ^ s_q.lfsr[TAP-1]};
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s_q <= '{lfsr: SEED};
    else
      s_q <= s_d;
  end

  assign state = s_q.lfsr;
endmodule

// File: adc_output_format_config.sv
// output formatter: staged/active registers, offset, format, patterns, invert, output gating
//
// Behaviour
// [RULE1] A signed 6-bit offset from -32 to +31 LSBs, zero by default, is added to each code.
// [RULE2] A 3-bit selector replaces data with midscale, +FS, -FS, checkerboard or long PRBS.
// [RULE3] The long PRBS generator is held in reset while its reset bit is one.
// [RULE4] The short PRBS generator is held in reset while its reset bit is one.
// [RULE5] The output disable bit set to one disables the data outputs, zero enables them.
// [RULE6] The outside party drives the active-low enable pin high for outputs to be enabled.
// [RULE7] The invert bit set to one inverts every output data bit.
// [RULE8] A 2-bit format field selects offset binary (00) or twos complement (01).
// [RULE9] The clock polarity bit set to one inverts the data output clock.
// [RULE10] Writes land in a staged copy and a commit bit copies them into the active set.
// [RULE11] Offset and format apply before inversion, which is the last step.
`timescale 1ns/1ns
module adc_output_format_config #(
  parameter int DATA_W = 14
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port from serial front end
  input wire adc_fmt_pkg::regreq_t regReq,
  output logic [7:0] regRdata,
  // converter samples, offset binary
  input wire logic [DATA_W-1:0] sampleIn,
  input wire logic sampleValid,
  // output pins
  input wire logic outputEnablePinActiveLow,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOutOe_n,
  output logic dataClkOut,
  // active settings visible to analog side
  output logic [7:0] referenceSelect
);
  typedef struct packed {
    adc_fmt_pkg::regset_t staged;
    adc_fmt_pkg::regset_t active;
    logic [7:0] rdata;
    logic [DATA_W-1:0] dout;
    logic doutOe_n;
    logic dclk;
    logic checkerPhase;
  } state_t;

  // both register copies come out of reset with these values
  localparam adc_fmt_pkg::regset_t REG_RESET = '{
    testPattern: adc_fmt_pkg::RST_TEST_PATTERN,
    offsetAdjust: adc_fmt_pkg::RST_OFFSET_ADJUST,
    outputConfig: adc_fmt_pkg::RST_OUTPUT_CONFIG,
    clockEdge: adc_fmt_pkg::RST_CLOCK_EDGE,
    reference: adc_fmt_pkg::RST_REFERENCE};

  state_t s_q;
  state_t s_d;
  logic [22:0] longPrbs;
  logic [8:0] shortPrbs;

  // sequence generators advance once per valid sample
  prbs_gen #(.WIDTH(23), .TAP(18), .SEED(adc_fmt_pkg::LONG_PRBS_SEED)) u_long (
    .mclk(mclk),
    .rst(rst),
    .holdReset(s_q.active.testPattern[adc_fmt_pkg::LONG_RST_BIT]), // [RULE3]
    .advance(sampleValid),
    .state(longPrbs)
  );

  prbs_gen #(.WIDTH(9), .TAP(5), .SEED(adc_fmt_pkg::SHORT_PRBS_SEED)) u_short (
    .mclk(mclk),
    .rst(rst),
    .holdReset(s_q.active.testPattern[adc_fmt_pkg::SHORT_RST_BIT]), // [RULE4]
    .advance(sampleValid),
    .state(shortPrbs)
  );

  // saturating signed add in offset-binary domain
  function automatic logic [DATA_W-1:0] addOffset(input logic [DATA_W-1:0] code,
                                                   input logic [5:0] offs);
    logic signed [DATA_W+1:0] sum;
    sum = $signed({2'b00, code}) + $signed({{(DATA_W-4){offs[5]}}, offs});
    if (sum < 0)
      addOffset = '0;
    else if (sum > $signed({2'b00, {DATA_W{1'b1}}}))
      addOffset = '1;
    else
      addOffset = sum[DATA_W-1:0];
  endfunction

  // offset first, then an msb flip turns offset binary into twos complement
  function automatic logic [DATA_W-1:0] formatSample(input logic [DATA_W-1:0] raw,
                                                     input logic [5:0] offs,
                                                     input logic [1:0] fmt);
    logic [DATA_W-1:0] result;
    result = addOffset(raw, offs); // [RULE1] [RULE11]
    if (fmt == adc_fmt_pkg::FMT_TWOS)
      result[DATA_W-1] = ~result[DATA_W-1]; // [RULE8] [RULE11]
    return result;
  endfunction

  // test patterns replace the formatted sample and skip offset and format
  function automatic logic [DATA_W-1:0] patternCode(input logic [2:0] pat,
                                                    input logic [DATA_W-1:0] formatted,
                                                    input logic phase,
                                                    input logic [22:0] longSeq,
                                                    input logic [8:0] shortSeq);
    logic [DATA_W-1:0] result;
    result = formatted;
    case (pat)
      adc_fmt_pkg::PAT_OFF: result = formatted;
      adc_fmt_pkg::PAT_MID: result = {1'b1, {(DATA_W-1){1'b0}}}; // [RULE2]
      adc_fmt_pkg::PAT_POS_FS: result = '1; // [RULE2]
      adc_fmt_pkg::PAT_NEG_FS: result = '0; // [RULE2]
      adc_fmt_pkg::PAT_CHECKER:
        result = phase ? {(DATA_W/2){2'b01}} : {(DATA_W/2){2'b10}}; // [RULE2]
      adc_fmt_pkg::PAT_LONG_PRBS: result = longSeq[DATA_W-1:0]; // [RULE2] [RULE3]
      default: result = {{(DATA_W-9){1'b0}}, shortSeq}; // [RULE4]
    endcase
    return result;
  endfunction

  // reads see the staged copy; unmapped and commit addresses read zero
  function automatic logic [7:0] readStaged(input adc_fmt_pkg::regset_t regs,
                                            input logic [7:0] addr);
    logic [7:0] result;
    result = 8'h00;
    case (addr)
      adc_fmt_pkg::ADDR_TEST_PATTERN: result = regs.testPattern;
      adc_fmt_pkg::ADDR_OFFSET_ADJUST: result = regs.offsetAdjust;
      adc_fmt_pkg::ADDR_OUTPUT_CONFIG: result = regs.outputConfig;
      adc_fmt_pkg::ADDR_CLOCK_EDGE: result = regs.clockEdge;
      adc_fmt_pkg::ADDR_REFERENCE: result = regs.reference;
      default: result = 8'h00;
    endcase
    return result;
  endfunction

  // staged write; open pattern bits 7:6 are kept clear
  function automatic adc_fmt_pkg::regset_t writeStaged(input adc_fmt_pkg::regset_t regs,
                                                       input logic [7:0] addr,
                                                       input logic [7:0] data);
    adc_fmt_pkg::regset_t result;
    result = regs;
    case (addr)
      adc_fmt_pkg::ADDR_TEST_PATTERN: result.testPattern = {2'h0, data[5:0]};
      adc_fmt_pkg::ADDR_OFFSET_ADJUST: result.offsetAdjust = data;
      adc_fmt_pkg::ADDR_OUTPUT_CONFIG: result.outputConfig = data;
      adc_fmt_pkg::ADDR_CLOCK_EDGE: result.clockEdge = data;
      adc_fmt_pkg::ADDR_REFERENCE: result.reference = data;
      default: result = regs;
    endcase
    return result;
  endfunction

  // per-bit invert mask, applied as the very last step
  logic [DATA_W-1:0] invertMask;
  for (genvar b = 0; b < DATA_W; b++)
  begin : g_invert
    assign invertMask[b] = s_q.active.outputConfig[adc_fmt_pkg::INVERT_BIT]; // [RULE7]
  end

  always_comb
  begin
    logic [DATA_W-1:0] formatted;
    logic [DATA_W-1:0] code;
    logic [2:0] pat;
    logic [1:0] fmt;
    logic commitNow;
    formatted = '0;
    code = '0;
    pat = s_q.active.testPattern[adc_fmt_pkg::PAT_LSB +: 3];
    fmt = s_q.active.outputConfig[adc_fmt_pkg::FMT_LSB +: 2];
    commitNow = regReq.wrEn && regReq.addr == adc_fmt_pkg::ADDR_COMMIT &&
                regReq.wdata[adc_fmt_pkg::COMMIT_BIT];
    s_d = s_q;

    // staged writes; commit copies the whole set
    if (regReq.wrEn)
      s_d.staged = writeStaged(s_q.staged, regReq.addr, regReq.wdata);
    if (commitNow)
      s_d.active = s_q.staged; // [RULE10]

    // reads return staged copy; commit register self-clears
    if (regReq.rdEn)
      s_d.rdata = readStaged(s_q.staged, regReq.addr);

    // offset and format, then pattern substitution, then invert last
    if (sampleValid)
    begin
      s_d.checkerPhase = ~s_q.checkerPhase;
      formatted = formatSample(sampleIn, s_q.active.offsetAdjust[5:0], fmt);
      code = patternCode(pat, formatted, s_q.checkerPhase, longPrbs, shortPrbs);
      s_d.dout = code ^ invertMask; // [RULE7] [RULE11]
    end

    // output gating: register bit and external pin
    s_d.doutOe_n = s_q.active.outputConfig[adc_fmt_pkg::DISABLE_BIT] |
                   ~outputEnablePinActiveLow; // [RULE5] [RULE6]
    s_d.dclk = sampleValid ^ s_q.active.clockEdge[adc_fmt_pkg::CLKPOL_BIT]; // [RULE9]
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_q.staged <= REG_RESET;
      s_q.active <= REG_RESET;
      s_q.rdata <= 8'h00;
      s_q.dout <= '0;
      s_q.doutOe_n <= 1'b1;
      s_q.dclk <= 1'b0;
      s_q.checkerPhase <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  assign regRdata = s_q.rdata;
  assign dataOut = s_q.dout;
  assign dataOutOe_n = s_q.doutOe_n;
  assign dataClkOut = s_q.dclk;
  assign referenceSelect = s_q.active.reference;
endmodule

// File: rx_capture.sv
// far-side model: enable pin driver and output word capture
`timescale 1ns/1ns
module rx_capture (
  // clock and control
  input wire logic mclk,
  input wire logic wantOn,
  // pins
  input wire logic [13:0] dataOut,
  input wire logic dataOutOe_n,
  output logic pinActiveLow,
  output logic [13:0] capWord
);
  // pin high lets the register bit enable the outputs
  assign pinActiveLow = wantOn;
  // released bus shows inverse of last word
  always @(posedge mclk)
    capWord <= dataOutOe_n ? ~capWord : dataOut;
endmodule

// File: adc_fmt_monitor.sv
// checker: port-level assertions for the output formatter
`timescale 1ns/1ns
module adc_fmt_monitor #(
  parameter int DATA_W = 14
) (
  input wire logic mclk,
  input wire logic rst,
  input wire adc_fmt_pkg::regreq_t regReq,
  input wire logic [7:0] regRdata,
  input wire logic [DATA_W-1:0] sampleIn,
  input wire logic sampleValid,
  input wire logic outputEnablePinActiveLow,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic dataOutOe_n,
  input wire logic dataClkOut,
  input wire logic [7:0] referenceSelect
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_oe_pin: assert property (!outputEnablePinActiveLow |=> dataOutOe_n)
    else $error("outputs driven while enable pin low");
  chk_clk_follow: assert property (sampleValid != $past(sampleValid) && !regReq.wrEn
    && !$past(regReq.wrEn) |=> $changed(dataClkOut)) else $error("clock not following valid");
  chk_data_hold: assert property (!sampleValid |=> $stable(dataOut))
    else $error("data changed without sample");
  chk_unmapped_rd: assert property (regReq.rdEn && regReq.addr == 8'h00 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_commit_rd: assert property (regReq.rdEn && regReq.addr == 8'hff |=> regRdata == 8'h00)
    else $error("commit read not zero");
  chk_rdata_hold: assert property (!regReq.rdEn |=> $stable(regRdata))
    else $error("read data moved");
  chk_ref_hold: assert property (!regReq.wrEn ##1 !regReq.wrEn |=> $stable(referenceSelect))
    else $error("active set moved without commit");
  chk_staged_rd: assert property (regReq.wrEn && regReq.addr inside {8'h10, 8'h14, 8'h16, 8'h18}
    ##1 regReq.rdEn && !regReq.wrEn && regReq.addr == $past(regReq.addr)
    |=> regRdata == $past(regReq.wdata, 2)) else $error("staged read mismatch");
endmodule
bind adc_output_format_config adc_fmt_monitor #(.DATA_W(DATA_W)) mon (.*);

// File: test_adc_output_format_config.sv
// testbench for the output formatter
`timescale 1ns/1ns
module test_adc_output_format_config;
  logic mclk = 0, rst = 1, sampleValid = 0, wantOn = 1, pinN, dataOutOe_n, dataClkOut;
  adc_fmt_pkg::regreq_t regReq = '0;
  logic [7:0] regRdata, referenceSelect, off;
  logic [13:0] sampleIn = '0, dataOut, capWord, a, s, e;
  logic [31:0] lf = 32'h0001480f;
  int fails = 0, cmp_count = 0;
  always #5 mclk = ~mclk;
  adc_output_format_config uut (.mclk(mclk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
    .sampleIn(sampleIn), .sampleValid(sampleValid), .outputEnablePinActiveLow(pinN),
    .dataOut(dataOut), .dataOutOe_n(dataOutOe_n), .dataClkOut(dataClkOut),
    .referenceSelect(referenceSelect));
  rx_capture far (.mclk(mclk), .wantOn(wantOn), .dataOut(dataOut), .dataOutOe_n(dataOutOe_n),
    .pinActiveLow(pinN), .capWord(capWord));
  function automatic logic [31:0] nx();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function automatic logic [13:0] fexp(logic [13:0] x, logic [5:0] o, logic tw, logic inv);
    int v;
    logic [13:0] r;
    v = int'(x) + int'($signed(o));
    r = v < 0 ? 14'h0000 : (v > 16383 ? 14'h3fff : v[13:0]);
    if (tw) r[13] = ~r[13];
    return inv ? ~r : r;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge mclk);
    regReq = '{1'b1, 1'b0, ad, d};
    @(negedge mclk);
    regReq.wrEn = 0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(negedge mclk);
    regReq = '{1'b0, 1'b1, ad, 8'h00};
    @(negedge mclk);
    regReq.rdEn = 0;
    chk(16'(regRdata), 16'(e));
  endtask
  task automatic wrrd(input logic [7:0] ad, input logic [7:0] d, input logic [7:0] ex);
    @(negedge mclk);
    regReq = '{1'b1, 1'b0, ad, d};
    @(negedge mclk);
    regReq = '{1'b0, 1'b1, ad, 8'h00};
    @(negedge mclk);
    regReq.rdEn = 0;
    chk(16'(regRdata), 16'(ex));
  endtask
  task automatic cm();
    wr(8'hff, 8'h01);
    @(negedge mclk);
  endtask
  task automatic smp(input logic [13:0] x);
    @(negedge mclk);
    sampleIn = x;
    sampleValid = 1;
    @(negedge mclk);
    sampleValid = 0;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #100000;
    fails++;
    end_sim();
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    @(negedge mclk) rst = 0;
    rd(8'h0d, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h16, 8'h00);
    rd(8'h18, 8'hc0);
    rd(8'h00, 8'h00);
    rd(8'hff, 8'h00);
    wrrd(8'h10, 8'h2a, 8'h2a);
    rd(8'h10, 8'h2a);
    wrrd(8'h0d, 8'hc3, 8'h03);
    wr(8'h0d, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      off = i < 4 ? 8'({6'h1f, 6'h20, 6'h00, 6'h3f} >> (6 * i)) : 8'(nx());
      s = i < 4 ? (i[0] ? 14'h3fff : 14'h0000) : 14'(nx());
      a = 14'(nx());
      wr(8'h10, {2'h0, off[5:0]});
      wr(8'h14, {5'h00, a[1], 1'b0, a[0]});
      cm();
      smp(s);
      e = fexp(s, off[5:0], a[0], a[1]);
      chk(16'(dataOut), 16'(e));
      chk(16'(dataOutOe_n), 16'h0000);
      @(negedge mclk);
      chk(16'(capWord), 16'(e));
    end
    wr(8'h14, 8'h00);
    wr(8'h10, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h0d, 8'(i + 1));
      cm();
      smp(14'(nx()));
      chk(16'(dataOut), 16'(14'({14'h0000, 14'h3fff, 14'h2000} >> (14 * i))));
    end
    wr(8'h0d, 8'h04);
    cm();
    smp(14'h0000);
    a = dataOut;
    smp(14'h0000);
    chk(16'(a ^ dataOut), 16'h3fff);
    chk(16'(a == 14'h2aaa || a == 14'h1555), 16'h0001);
    wr(8'h0d, 8'h25);
    cm();
    smp(14'h0000);
    smp(14'h0000);
    chk(16'(dataOut), 16'h3fff);
    wr(8'h0d, 8'h05);
    cm();
    smp(14'h0000);
    a = dataOut;
    smp(14'h0000);
    chk(16'(a !== dataOut), 16'h0001);
    wr(8'h0d, 8'h16);
    cm();
    smp(14'h0000);
    smp(14'h0000);
    chk(16'(dataOut), 16'h01ff);
    wr(8'h0d, 8'h06);
    cm();
    smp(14'h0000);
    a = dataOut;
    smp(14'h0000);
    chk(16'(a !== dataOut), 16'h0001);
    wr(8'h14, 8'h10);
    cm();
    smp(14'h0000);
    chk(16'(dataOutOe_n), 16'h0001);
    wr(8'h14, 8'h00);
    wr(8'h16, 8'h80);
    cm();
    wantOn = 0;
    @(negedge mclk);
    chk(16'({dataOutOe_n, dataClkOut}), 16'h0003);
    smp(14'h0000);
    chk(16'(dataClkOut), 16'h0000);
    end_sim();
  end
endmodule
